/* design/acc_conv_ctrl.sv */
// converter control: register slave, sequencing, selection and pin masking
`timescale 1ns/1ns
`default_nettype none
// How it works
// - a set input-disable bit turns off that pin buffer; pin value reads 0
// - ten-bit code by successive approximation, zero is ground, top is ref
// - three-bit field picks supply, external pin, 1.1 V or 2.56 V reference
// - four-bit field picks single inputs or a differential pair, gain 1x/20x
// - single-ended inputs bypass the gain amplifier entirely
// - code 1111 connects the on-chip temperature sensor
// - selections act only while the enable bit is set; else powered down
// - result right-aligned by default, left-aligned when left-adjust set
// - reading the low byte locks results until the high byte is read
// - done flag and request still rise when a locked result is lost
// - writing start begins a conversion; start reads 1 until completion
// - a channel change mid conversion waits until that conversion ends
// - auto trigger rising edge resets the prescaler and starts conversion
// - trigger edges during a conversion are ignored; a held level does not retrigger
// - done flag as source runs free after one software start
// - with auto trigger on, a software start still runs one conversion
// - own conversion-complete request rises when a conversion finishes
// - normal conversion 13 converter clocks, first after enable 25
// - prescaler counts while enabled and is held in reset otherwise
// - on completion results written unless locked, flag set, start cleared if single
// - software start begins at the next converter clock edge

module acc_conv_ctrl
    import acc_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [ACC_PIN_W-1:0]  pin_in,
    input  wire logic [ACC_TRIG_W-1:0] trig_event,
    input  wire logic                  cmp_raw,
    output logic [ACC_PIN_W-1:0]       pin_value,
    output logic [ACC_PIN_W-1:0]       digin_off,
    output logic                       conv_power_on,
    output logic [3:0]                 ref_onehot,
    output logic [1:0]                 mux_pos_sel,
    output logic [1:0]                 mux_neg_sel,
    output logic                       amp_bypass,
    output logic                       amp_gain_20x,
    output logic                       temp_sensor_sel,
    output logic                       sample_hold,
    output logic [ACC_RES_W-1:0]       dac_code,
    output logic                       conv_irq
);

    typedef struct packed {
        logic [7:0]           sel;
        logic [7:0]           sel_act;
        logic                 en;
        logic                 ate;
        logic                 ie;
        logic                 flag;
        logic                 start_req;
        logic                 first;
        logic                 locked;
        logic                 tick;
        logic                 trig_prev;
        logic                 irq;
        logic [ACC_PS_W-1:0]  ps;
        logic [ACC_TS_W-1:0]  ts;
        logic [ACC_PIN_W-1:0] didr;
        logic [ACC_PIN_W-1:0] p1;
        logic [ACC_PIN_W-1:0] p2;
        logic [ACC_PIN_W-1:0] p3;
        logic [ACC_PIN_W-1:0] pf;
        logic [ACC_PIN_W-1:0] pin_val;
        logic [7:0]           pcnt;
        logic [ACC_RES_W-1:0] result;
        logic [3:0]           ref_oh;
        logic [1:0]           pos;
        logic [1:0]           neg;
        logic                 bypass;
        logic                 g20;
        logic                 temp;
        logic                 awready;
        logic                 aw_ok;
        logic [7:0]           awa;
        logic                 wready;
        logic                 w_ok;
        logic [31:0]          wd;
        logic                 wstb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } acc_ctrl_t;

    acc_ctrl_t r;
    acc_ctrl_t n;

    logic                 core_busy;
    logic                 core_done;
    logic                 core_start;
    logic [ACC_RES_W-1:0] core_result;

    // {bypass, pos, neg, gain 20x, temp} for a channel and gain code
    function automatic logic [6:0] acc_chan_dec(input logic [3:0] code);
        if (code == ACC_CH_TEMP)
            return {1'b1, 2'h0, 2'h0, 1'b0, 1'b1};
        if (code <= ACC_CH_SINGLE_MAX)
            return {1'b1, code[1:0], 2'h0, 1'b0, 1'b0};
        return {1'b0, code[3] ? ACC_POS_HI : ACC_POS_LO, code[1:0],
                code[2], 1'b0};
    endfunction

    function automatic logic [3:0] acc_ref_dec(input logic [2:0] sel);
        unique case (sel)
            ACC_REF_VCC: return ACC_RO_VCC;
            ACC_REF_EXT: return ACC_RO_EXT;
            ACC_REF_1V1: return ACC_RO_1V1;
            default:     return ACC_RO_2V56;
        endcase
    endfunction

    function automatic logic acc_mapped(input logic [7:0] a);
        return a == ACC_OFS_SEL  || a == ACC_OFS_CTLA ||
               a == ACC_OFS_CTLB || a == ACC_OFS_RESL ||
               a == ACC_OFS_RESH || a == ACC_OFS_DIDR;
    endfunction

    // a start is issued only on a converter clock tick
    assign core_start = r.tick && r.start_req && !core_busy && r.en;

    acc_sar_core u_core (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .enable    (r.en),
        .tick      (r.tick),
        .start     (core_start),
        .long_conv (r.first),
        .cmp_raw   (cmp_raw),
        .busy      (core_busy),
        .done      (core_done),
        .hold      (sample_hold),
        .result    (core_result),
        .dac_code  (dac_code)
    );

    logic                 wr_go;
    logic                 rd_go;
    logic                 free_mode;
    logic                 trig_lvl;
    logic                 trig_go;
    logic                 hit;
    logic [7:0]           trig_vec;
    logic [15:0]          aligned;

    always_comb begin
        n         = r;
        wr_go     = r.aw_ok && r.w_ok && !r.bvalid;
        rd_go     = s_axi_arvalid && r.arready;
        free_mode = r.ate && (r.ts == ACC_TS_FREE);
        trig_vec  = {trig_event, r.flag};
        trig_lvl  = trig_vec[r.ts];
        aligned   = acc_align(r.result, r.sel[ACC_SEL_LEFT]);
        // the flag only rises again after software clears it
        trig_go   = r.en && r.ate && !free_mode && trig_lvl &&
                    !r.trig_prev && !r.start_req && !core_busy;
        n.trig_prev = trig_lvl;

        // an issued start is consumed; start then reads through busy
        if (core_start) begin
            n.start_req = 1'b0;
            n.first     = 1'b0;
        end

        // write address and data are taken in either order
        if (s_axi_awvalid && r.awready) begin
            n.aw_ok = 1'b1;
            n.awa   = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_ok = 1'b1;
            n.wd   = s_axi_wdata;
            n.wstb = s_axi_wstrb[0];
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_go) begin
            n.aw_ok  = 1'b0;
            n.w_ok   = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = acc_mapped(r.awa) ? ACC_RESP_OK : ACC_RESP_ERR;
            if (r.wstb) begin
                case (r.awa)
                    ACC_OFS_SEL: n.sel = r.wd[7:0];
                    ACC_OFS_CTLA: begin
                        n.en  = r.wd[ACC_CTLA_EN];
                        n.ate = r.wd[ACC_CTLA_ATE];
                        n.ie  = r.wd[ACC_CTLA_IE];
                        n.ps  = r.wd[ACC_PS_W-1:0];
                        if (r.wd[ACC_CTLA_IF]) begin
                            n.flag = 1'b0;
                        end
                        if (r.wd[ACC_CTLA_SC] && r.wd[ACC_CTLA_EN]) begin
                            n.start_req = 1'b1;
                        end
                    end
                    ACC_OFS_CTLB: n.ts = r.wd[ACC_TS_W-1:0];
                    ACC_OFS_DIDR: n.didr = r.wd[ACC_PIN_W-1:0];
                    default: ;
                endcase
            end
        end

        // reads; result reads move the lock
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (rd_go) begin
            n.rvalid = 1'b1;
            n.rresp  = acc_mapped(s_axi_araddr) ? ACC_RESP_OK : ACC_RESP_ERR;
            n.rdata  = '0;
            case (s_axi_araddr)
                ACC_OFS_SEL:  n.rdata[7:0] = r.sel;
                ACC_OFS_CTLA: n.rdata[7:0] = {r.en,
                    r.start_req | core_busy | (core_done & free_mode),
                    r.ate, r.flag, r.ie, r.ps};
                ACC_OFS_CTLB: n.rdata[ACC_TS_W-1:0] = r.ts;
                ACC_OFS_RESL: begin
                    n.rdata[7:0] = aligned[7:0];
                    n.locked     = 1'b1;
                end
                ACC_OFS_RESH: begin
                    n.rdata[7:0] = aligned[15:8];
                    n.locked     = 1'b0;
                end
                ACC_OFS_DIDR: n.rdata[ACC_PIN_W-1:0] = r.didr;
                default: ;
            endcase
        end

        // prescaler divides the system clock into converter ticks
        hit    = (r.pcnt == acc_pre_limit(r.ps));
        n.tick = r.en && hit;
        n.pcnt = hit ? '0 : r.pcnt + 8'h01;
        if (trig_go) begin
            n.start_req = 1'b1;
            n.pcnt      = '0;
            n.tick      = 1'b0;
        end

        // completion: flag set wins over a clear in the same cycle
        if (core_done) begin
            if (!r.locked) begin
                n.result = core_result;
            end
            n.flag = 1'b1;
            if (free_mode) begin
                n.start_req = 1'b1;
            end
        end

        // first conversion after enabling takes the long path
        if (!r.en && n.en) begin
            n.first = 1'b1;
        end
        if (!n.en) begin
            n.start_req = 1'b0;
            n.pcnt      = '0;
            n.tick      = 1'b0;
        end

        // selection follows the register only between conversions
        if (n.en && !core_busy && !core_start) begin
            n.sel_act = n.sel;
        end
        {n.bypass, n.pos, n.neg, n.g20, n.temp} =
            n.en ? acc_chan_dec(n.sel_act[ACC_CHAN_W-1:0]) : '0;
        n.ref_oh = n.en ?
            acc_ref_dec(n.sel_act[ACC_REF_LSB +: ACC_REF_W]) : '0;

        // pin filter: a bit moves once the last two stages agree
        n.p1      = pin_in;
        n.p2      = r.p1;
        n.p3      = r.p2;
        n.pf      = (r.p3 & ~(r.p2 ^ r.p3)) | (r.pf & (r.p2 ^ r.p3));
        n.pin_val = r.pf & ~r.didr;

        n.irq     = n.flag && n.ie;
        n.awready = !n.aw_ok && !n.bvalid;
        n.wready  = !n.w_ok && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // every output is a register field
    assign s_axi_awready   = r.awready;
    assign s_axi_wready    = r.wready;
    assign s_axi_bresp     = r.bresp;
    assign s_axi_bvalid    = r.bvalid;
    assign s_axi_arready   = r.arready;
    assign s_axi_rdata     = r.rdata;
    assign s_axi_rresp     = r.rresp;
    assign s_axi_rvalid    = r.rvalid;
    assign pin_value       = r.pin_val;
    assign digin_off       = r.didr;
    assign conv_power_on   = r.en;
    assign ref_onehot      = r.ref_oh;
    assign mux_pos_sel     = r.pos;
    assign mux_neg_sel     = r.neg;
    assign amp_bypass      = r.bypass;
    assign amp_gain_20x    = r.g20;
    assign temp_sensor_sel = r.temp;
    assign conv_irq        = r.irq;

    default clocking acc_cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence low_read_s;
        rd_go && s_axi_araddr == ACC_OFS_RESL;
    endsequence

    sequence high_read_s;
        rd_go && s_axi_araddr == ACC_OFS_RESH;
    endsequence

    pin_mask_a: assert property (
        (r.pin_val & $past(r.didr)) == '0)
        else $error("disabled pin reads nonzero");

    lock_set_a: assert property (low_read_s |=> r.locked)
        else $error("low byte read did not lock results");

    lock_keep_a: assert property (
        r.locked && core_done |=> $stable(r.result))
        else $error("locked result was overwritten");

    lock_clear_a: assert property (high_read_s |=> !r.locked)
        else $error("high byte read did not unlock results");

    flag_lost_a: assert property (core_done |=> r.flag)
        else $error("done flag missing after completion");

    start_busy_a: assert property (core_start |=> core_busy && !r.start_req)
        else $error("issued start did not run");

    start_clear_a: assert property (
        core_done && !free_mode && !wr_go |=> !r.start_req && !core_busy)
        else $error("start still pending after single conversion");

    chan_lock_a: assert property (
        core_busy && $past(core_busy) |-> $stable(r.sel_act))
        else $error("selection changed during conversion");

    trig_reset_a: assert property (trig_go |=> r.pcnt == '0 ##1 !r.tick)
        else $error("trigger did not reset prescaler");

    presc_hold_a: assert property (!r.en |-> r.pcnt == '0 && !r.tick)
        else $error("prescaler ran while disabled");

    tick_start_a: assert property ($rose(core_busy) |-> $past(r.tick))
        else $error("conversion began off a converter tick");

    free_run_a: assert property (
        core_done && free_mode && r.en |=> r.start_req)
        else $error("free running mode did not restart");

    irq_a: assert property (r.flag && r.ie |-> r.irq)
        else $error("completion request missing");

endmodule // acc_conv_ctrl

`default_nettype wire

/* design/acc_pkg.sv */
// constants, types and helpers shared by the converter control block
package acc_pkg;

    // register byte addresses on the register bus
    localparam logic [7:0] ACC_OFS_SEL  = 8'h00;
    localparam logic [7:0] ACC_OFS_CTLA = 8'h04;
    localparam logic [7:0] ACC_OFS_CTLB = 8'h08;
    localparam logic [7:0] ACC_OFS_RESL = 8'h0C;
    localparam logic [7:0] ACC_OFS_RESH = 8'h10;
    localparam logic [7:0] ACC_OFS_DIDR = 8'h14;

    // field positions and widths
    localparam int ACC_CTLA_EN  = 7;
    localparam int ACC_CTLA_SC  = 6;
    localparam int ACC_CTLA_ATE = 5;
    localparam int ACC_CTLA_IF  = 4;
    localparam int ACC_CTLA_IE  = 3;
    localparam int ACC_SEL_LEFT = 7;
    localparam int ACC_REF_LSB  = 4;
    localparam int ACC_REF_W    = 3;
    localparam int ACC_CHAN_W   = 4;
    localparam int ACC_PS_W     = 3;
    localparam int ACC_TS_W     = 3;
    localparam int ACC_PIN_W    = 6;
    localparam int ACC_RES_W    = 10;
    localparam int ACC_TRIG_W   = 7;

    // field encodings
    localparam logic [3:0] ACC_CH_SINGLE_MAX = 4'h3;
    localparam logic [3:0] ACC_CH_TEMP       = 4'hF;
    localparam logic [1:0] ACC_POS_LO        = 2'h0;
    localparam logic [1:0] ACC_POS_HI        = 2'h2;
    localparam logic [2:0] ACC_REF_VCC       = 3'h0;
    localparam logic [2:0] ACC_REF_EXT       = 3'h1;
    localparam logic [2:0] ACC_REF_1V1       = 3'h2;
    localparam logic [3:0] ACC_RO_VCC        = 4'h1;
    localparam logic [3:0] ACC_RO_EXT        = 4'h2;
    localparam logic [3:0] ACC_RO_1V1        = 4'h4;
    localparam logic [3:0] ACC_RO_2V56       = 4'h8;
    localparam logic [2:0] ACC_TS_FREE       = 3'h0;
    localparam logic [1:0] ACC_RESP_OK       = 2'h0;
    localparam logic [1:0] ACC_RESP_ERR      = 2'h2;

    // conversion timing in converter clock ticks
    localparam logic [4:0] ACC_CNT_ONE     = 5'h01;
    localparam logic [4:0] ACC_HOLD_AT     = 5'h01;
    localparam logic [4:0] ACC_BIT_FIRST   = 5'h02;
    localparam logic [4:0] ACC_BIT_LAST    = 5'h0B;
    localparam logic [4:0] ACC_DONE_AT     = 5'h0C;
    localparam logic [4:0] ACC_FIRST_EXTRA = 5'h0C;
    localparam logic [4:0] ACC_LEN_NORM    = 5'h0D;
    localparam logic [4:0] ACC_LEN_FIRST   = 5'h19;
    localparam logic [9:0] ACC_MSB_MASK    = 10'h200;

    typedef enum logic {ACC_IDLE, ACC_RUN} acc_core_st_t;

    // prescaler terminal count: divide by two to the power ps plus one
    function automatic logic [7:0] acc_pre_limit(input logic [2:0] ps);
        logic [8:0] span;
        span = 9'h002 << ps;
        return 8'(span - 9'h001);
    endfunction

    // {high byte, low byte} of a result in either alignment
    function automatic logic [15:0] acc_align(input logic [9:0] res,
                                              input logic       left);
        if (left)
            return {res[9:2], res[1:0], 6'h00};
        return {6'h00, res[9:8], res[7:0]};
    endfunction

endpackage

/* design/acc_sar_core.sv */
// successive approximation engine stepped by the converter clock enable
`timescale 1ns/1ns
`default_nettype none

module acc_sar_core
    import acc_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 enable,
    input  wire logic                 tick,
    input  wire logic                 start,
    input  wire logic                 long_conv,
    input  wire logic                 cmp_raw,
    output logic                      busy,
    output logic                      done,
    output logic                      hold,
    output logic [ACC_RES_W-1:0]      result,
    output logic [ACC_RES_W-1:0]      dac_code
);

    typedef struct packed {
        logic                 s1;
        logic                 s2;
        logic                 s3;
        logic                 cmp;
        acc_core_st_t         st;
        logic                 busy;
        logic [4:0]           cnt;
        logic [4:0]           base;
        logic [ACC_RES_W-1:0] mask;
        logic [ACC_RES_W-1:0] trial;
        logic [ACC_RES_W-1:0] result;
        logic                 done;
        logic                 hold;
    } acc_core_t;

    acc_core_t r;
    acc_core_t n;

    // start arrives on a tick, which is tick zero of the conversion
    always_comb begin
        n = r;
        n.done = 1'b0;
        // comparator filter: s1 feeds only s2
        n.s1 = cmp_raw;
        n.s2 = r.s1;
        n.s3 = r.s2;
        if (r.s2 == r.s3) begin
            n.cmp = r.s3;
        end
        unique case (r.st)
            ACC_IDLE: begin
                if (start) begin
                    n.st    = ACC_RUN;
                    n.cnt   = ACC_CNT_ONE;
                    n.base  = long_conv ? ACC_FIRST_EXTRA : '0;
                    n.mask  = ACC_MSB_MASK;
                    n.trial = ACC_MSB_MASK;
                end
            end
            ACC_RUN: begin
                if (tick) begin
                    n.cnt = r.cnt + ACC_CNT_ONE;
                    if (r.cnt == r.base + ACC_HOLD_AT) begin
                        n.hold = 1'b1;
                    end
                    // keep or drop the trial bit, then try the next one
                    if (r.cnt >= r.base + ACC_BIT_FIRST &&
                        r.cnt <= r.base + ACC_BIT_LAST) begin
                        n.trial = (r.cmp ? r.trial : r.trial & ~r.mask)
                                  | (r.mask >> 1);
                        n.mask  = r.mask >> 1;
                    end
                    if (r.cnt == r.base + ACC_DONE_AT) begin
                        n.st     = ACC_IDLE;
                        n.done   = 1'b1;
                        n.hold   = 1'b0;
                        n.result = r.trial;
                    end
                end
            end
        endcase
        // disabling powers the converter down mid conversion
        if (!enable) begin
            n.st   = ACC_IDLE;
            n.hold = 1'b0;
        end
        n.busy = (n.st == ACC_RUN);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign busy     = r.busy;
    assign done     = r.done;
    assign hold     = r.hold;
    assign result   = r.result;
    assign dac_code = r.trial;

    default clocking acc_cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    core_len_a: assert property (done |->
        r.cnt == ((r.base == '0) ? ACC_LEN_NORM : ACC_LEN_FIRST))
        else $error("conversion length is not 13 or 25 ticks");

    sar_first_a: assert property ($rose(r.busy) |->
        r.trial == ACC_MSB_MASK && !r.hold)
        else $error("approximation does not begin at mid scale");

endmodule // acc_sar_core

`default_nettype wire

/* testbench/acc_analog_model.sv */
// behavioural analog side: comparator against the trial code, pin levels
`timescale 1ns/1ns
`default_nettype none
module acc_analog_model
    import acc_pkg::*;
(
    input  wire logic [9:0]           ain,
    input  wire logic [5:0]           pins,
    input  wire logic [ACC_RES_W-1:0] dac_code,
    output logic                      cmp_raw,
    output logic [5:0]                pin_in
);
    // input sits half a step above ain, so the search settles on ain
    assign cmp_raw = (dac_code <= ain);
    assign pin_in  = pins;
endmodule // acc_analog_model
`default_nettype wire

/* testbench/adc_conversion_control_tb.sv */
// bench: register accesses, conversions, alignment, lock and trigger
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
    n_errors++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module adc_conversion_control_tb;
    import acc_pkg::*;
    logic clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmp_raw, conv_power_on;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [5:0]  pin_in, pin_value, pins;
    logic [6:0]  trig_event;
    logic [5:0]  digin_off;
    logic [3:0]  ref_onehot;
    logic [1:0]  mux_pos_sel;
    logic        amp_bypass;
    logic [9:0]  dac_code, ain;
    int          n_errors, check_count, i;
    acc_conv_ctrl u_dut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .trig_event,
        .cmp_raw, .pin_value, .digin_off, .conv_power_on, .ref_onehot,
        .mux_pos_sel, .mux_neg_sel(), .amp_bypass, .amp_gain_20x(),
        .temp_sensor_sel(), .sample_hold(), .dac_code, .conv_irq());
    acc_analog_model u_ana (.ain, .pins, .dac_code, .cmp_raw, .pin_in);
    // write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    // read: data and response taken at the edge that sees rvalid
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // poll the done flag, bounded so a stuck converter still ends
    task automatic wait_flag;
        d = 32'h0000_0000;
        for (i = 0; i < 200 && d[ACC_CTLA_IF] !== 1'b1; i++)
            rd(ACC_OFS_CTLA);
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // watchdog: far beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        give_verdict;
    end
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, trig_event} = 9'h000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        ain = 10'h2A5;
        pins = 6'h3F;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ACC_OFS_DIDR); `CHK("didr reset", 32'h0000_0000, d)
        wr(ACC_OFS_DIDR, 8'hD5);
        rd(ACC_OFS_DIDR); `CHK("didr", 32'h0000_0015, d)
        `CHK("pin value", 6'h2A, pin_value)
        `CHK("digin off", 6'h15, digin_off)
        rd(8'h40); `CHK("unmapped", ACC_RESP_ERR, resp)
        `CHK("power off", 1'b0, conv_power_on)
        wr(ACC_OFS_SEL, 8'h01);
        wr(ACC_OFS_CTLA, 8'hC3);
        rd(ACC_OFS_CTLA); `CHK("busy", 1'b1, d[ACC_CTLA_SC])
        `CHK("power on", 1'b1, conv_power_on)
        `CHK("ref", ACC_RO_VCC, ref_onehot)
        `CHK("bypass", 1'b1, amp_bypass)
        `CHK("pos sel", 2'h1, mux_pos_sel)
        wait_flag; `CHK("start clr", 1'b0, d[ACC_CTLA_SC])
        rd(ACC_OFS_RESL); `CHK("low r", 32'h0000_00A5, d)
        rd(ACC_OFS_RESH); `CHK("high r", 32'h0000_0002, d)
        wr(ACC_OFS_SEL, 8'h81);
        wr(ACC_OFS_CTLA, 8'hD3);
        wait_flag;
        rd(ACC_OFS_RESL); `CHK("low l", 32'h0000_0040, d)
        rd(ACC_OFS_RESH); `CHK("high l", 32'h0000_00A9, d)
        // low read locks; the triggered result must be lost
        rd(ACC_OFS_RESL);
        ain <= 10'h0F0;
        wr(ACC_OFS_CTLB, 8'h01);
        wr(ACC_OFS_CTLA, 8'hB3);
        trig_event <= 7'h01;
        wait_flag; `CHK("trig flag", 1'b1, d[ACC_CTLA_IF])
        rd(ACC_OFS_RESH); `CHK("locked", 32'h0000_00A9, d)
        give_verdict;
    end
endmodule // adc_conversion_control_tb
`default_nettype wire
